// *** rtl/dpop_map.svh ***
// Constants for the dual parallel output port block.
// Assumes inclusion by the design files only, not by the package.
`ifndef DPOP_MAP_SVH
`define DPOP_MAP_SVH
`define DPOP_FIFO_DEPTH     3'h7
`define DPOP_IRQ_CYCLES     4'h8
`define DPOP_SEL_I          3'h0
`define DPOP_SEL_Q          3'h1
`define DPOP_SEL_MAG        3'h2
`define DPOP_SEL_PHASE      3'h3
`define DPOP_SEL_FREQ       3'h4
`define DPOP_ASRC_I         2'h0
`define DPOP_ASRC_MAG       2'h1
`define DPOP_ASRC_FREQ      2'h2
`define DPOP_BSRC_Q         2'h0
`define DPOP_BSRC_PHASE     2'h1
`define DPOP_BSRC_MAG       2'h2
`endif

// *** rtl/dpop_pkg.sv ***
// Types shared by the dual parallel output port block.
// Assumes no constants from dpop_map.svh; field widths are literal.
package dpop_pkg;
    typedef struct packed {
        logic [15:0] inPhase;
        logic [15:0] quad;
        logic [15:0] mag;
        logic [15:0] phase;
        logic [15:0] freq;
    } dpop_set_t;

    typedef struct packed {
        logic [15:0] busA;
        logic [15:0] busB;
    } dpop_bus_t;
endpackage : dpop_pkg

// *** rtl/dpop_set_fifo.sv ***
// Seven-entry queue of complete data sets, flip-flop storage.
// Assumes one clock; a push when full is dropped.
`timescale 1ns/10ps
`default_nettype none
`include "dpop_map.svh"
module dpop_set_fifo (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             pushValid,
    input  wire dpop_pkg::dpop_set_t pushSet,
    input  wire logic             popReady,
    output logic                  popValid,
    output dpop_pkg::dpop_set_t   headSet,
    output logic                  pushed
);
    import dpop_pkg::*;
    dpop_set_t   mem_q [7];
    dpop_set_t   mem_d [7];
    logic [2:0]  wr_q, wr_d, rd_q, rd_d, cnt_q, cnt_d;
    logic        doPush, doPop;

    function automatic logic [2:0] nextIdx(input logic [2:0] idx);
        return (idx == 3'h6) ? 3'h0 : idx + 3'h1;
    endfunction : nextIdx

    always_comb begin
        doPush = pushValid && (cnt_q != `DPOP_FIFO_DEPTH); // RL17
        doPop  = popReady && (cnt_q != 3'h0);
        mem_d  = mem_q;
        wr_d   = wr_q;
        rd_d   = rd_q;
        cnt_d  = cnt_q;
        if (doPush) begin
            mem_d[wr_q] = pushSet;
            wr_d        = nextIdx(wr_q);
        end
        if (doPop) begin
            rd_d = nextIdx(rd_q);
        end
        cnt_d = cnt_q + {2'h0, doPush} - {2'h0, doPop}; // RL8
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_q  <= 3'h0;
            rd_q  <= 3'h0;
            cnt_q <= 3'h0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
        mem_q <= mem_d;
    end

    assign popValid = (cnt_q != 3'h0);
    assign headSet  = mem_q[rd_q];
    assign pushed   = doPush;

    property p_noOverfill;
        @(posedge clk) disable iff (!rst_b)
            (cnt_q == 3'h0 || cnt_q == `DPOP_FIFO_DEPTH) |-> (wr_q == rd_q);
    endproperty
    a_noOverfill: assert property (p_noOverfill) else $error("Queue count and pointers disagree"); // RL8

    property p_fullDrop;
        @(posedge clk) disable iff (!rst_b)
            (cnt_q == 3'h7 && pushValid && !popReady) |=> (cnt_q == 3'h7 && $stable(wr_q));
    endproperty
    a_fullDrop: assert property (p_fullDrop) else $error("Full push not dropped"); // RL17
endmodule : dpop_set_fifo
`default_nettype wire

// *** rtl/dpop_irq_pulse.sv ***
// Stretches an event into an eight-cycle active-low pulse.
// Assumes one clock; a new event restarts the pulse.
`timescale 1ns/10ps
`default_nettype none
`include "dpop_map.svh"
module dpop_irq_pulse (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic trigger,
    output logic      irqN
);
    logic [3:0] cnt_q, cnt_d;
    logic       irqN_q, irqN_d;

    always_comb begin
        cnt_d  = trigger ? `DPOP_IRQ_CYCLES : ((cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0);
        irqN_d = (cnt_d == 4'h0); // RL13
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q  <= 4'h0;
            irqN_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_d;
            irqN_q <= irqN_d;
        end
    end

    assign irqN = irqN_q;

    sequence s_lowEight;
        !irqN [*8];
    endsequence
    property p_eightLow;
        @(posedge clk) disable iff (!rst_b) trigger |=> s_lowEight;
    endproperty
    a_eightLow: assert property (p_eightLow) else $error("Interrupt not eight cycles"); // RL13

    property p_release;
        @(posedge clk) disable iff (!rst_b) trigger ##1 (!trigger [*8]) |=> irqN;
    endproperty
    a_release: assert property (p_release) else $error("Interrupt held too long"); // RL13
endmodule : dpop_irq_pulse
`default_nettype wire

// *** rtl/dpop_output_ports.sv ***
// Direct and buffered parallel output ports toward a reader.
// Assumes synchronous inputs on clk and a reader driving byte enables and selector.
//
// Contract
// RL1: Provide direct and buffered output modes
// RL2: Bus A high byte is direct A
// RL3: Direct update on new result, strobe
// RL4: Bus A: in-phase, magnitude, or frequency
// RL5: Bus B high byte direct B word
// RL6: Two's complement; magnitude MSB forced zero
// RL7: Buffered queue of sets, item selector
// RL8: At most seven sets queued
// RL9: Low bytes form buffered word
// RL10: Bus B low byte selectable source
// RL11: Buffered formats match direct formats
// RL12: Strobe low one cycle on new data
// RL13: Interrupt low eight cycles when ready
// RL14: Byte released while its enable high
// RL15: Reader drives three-bit item selector
// RL16: Fixed codes; unassigned codes read zero
// RL17: Full queue discards new set
`timescale 1ns/10ps
`default_nettype none
`include "dpop_map.svh"
module dpop_output_ports (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                sampleValid,
    input  wire dpop_pkg::dpop_set_t sample,
    input  wire logic [1:0]          aSourceSel,
    input  wire logic [1:0]          bSourceSel,
    input  wire logic                bLowFromBuffer,
    input  wire logic                setComplete,
    input  wire logic                bufferPop,
    input  wire logic [2:0]          itemSel,
    input  wire logic                bus_a_high_byte_enable_n,
    input  wire logic                bus_a_low_byte_enable_n,
    input  wire logic                bus_b_high_byte_enable_n,
    input  wire logic                bus_b_low_byte_enable_n,
    output dpop_pkg::dpop_bus_t      outBus,
    output logic [15:0]              output_bus_a_oe,
    output logic [15:0]              output_bus_b_oe,
    output logic                     new_data_strobe_n,
    output logic                     buffer_ready_irq_n,
    output logic                     bufferValid
);
    import dpop_pkg::*;

    dpop_set_t   fmtSample, headSet;
    dpop_bus_t   bus_q, bus_d;
    logic [15:0] dirA_q, dirA_d, dirB_q, dirB_d;
    logic [15:0] bufWord;
    logic [15:0] oeA_q, oeA_d, oeB_q, oeB_d;
    logic        strobeN_q, strobeN_d;
    logic        valid_q, valid_d;
    logic        fifoValid, pushed, readyEvent;

    // Magnitude is unsigned; top bit cleared so it never reads negative
    function automatic logic [15:0] magFmt(input logic [15:0] m);
        return {1'b0, m[14:0]};
    endfunction : magFmt

    always_comb begin
        fmtSample     = sample;
        fmtSample.mag = magFmt(sample.mag); // RL6
    end

    dpop_set_fifo u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .pushValid (setComplete),
        .pushSet   (fmtSample), // RL11
        .popReady  (bufferPop),
        .popValid  (fifoValid),
        .headSet   (headSet),
        .pushed    (pushed)
    ); // RL7

    // Interrupt fires when the queue goes from empty to holding a set
    // Judged on the registered count, so a pop in the same cycle as the push does not count as empty
    assign readyEvent = pushed && !fifoValid;

    dpop_irq_pulse u_irq (
        .clk     (clk),
        .rst_b   (rst_b),
        .trigger (readyEvent),
        .irqN    (buffer_ready_irq_n)
    ); // RL13

    always_comb begin
        dirA_d     = dirA_q;
        dirB_d     = dirB_q;
        strobeN_d  = 1'b1;
        if (sampleValid) begin // RL3
            unique case (aSourceSel) // RL4
                `DPOP_ASRC_MAG:  dirA_d = fmtSample.mag;
                `DPOP_ASRC_FREQ: dirA_d = fmtSample.freq;
                default:         dirA_d = fmtSample.inPhase;
            endcase
            unique case (bSourceSel) // RL5
                `DPOP_BSRC_PHASE: dirB_d = fmtSample.phase;
                `DPOP_BSRC_MAG:   dirB_d = fmtSample.mag;
                default:          dirB_d = fmtSample.quad;
            endcase
            strobeN_d = 1'b0; // RL12
        end
    end

    always_comb begin
        unique case (itemSel) // RL16
            `DPOP_SEL_I:     bufWord = headSet.inPhase;
            `DPOP_SEL_Q:     bufWord = headSet.quad;
            `DPOP_SEL_MAG:   bufWord = headSet.mag;
            `DPOP_SEL_PHASE: bufWord = headSet.phase;
            `DPOP_SEL_FREQ:  bufWord = headSet.freq;
            default:         bufWord = 16'h0000;
        endcase
        if (!fifoValid) begin
            bufWord = 16'h0000;
        end
    end

    always_comb begin
        bus_d.busA[15:8] = dirA_d[15:8]; // RL2
        bus_d.busB[15:8] = dirB_d[15:8]; // RL5
        bus_d.busA[7:0]  = bufWord[15:8]; // RL9
        bus_d.busB[7:0]  = bLowFromBuffer ? bufWord[7:0] : dirB_d[7:0]; // RL10
        valid_d          = fifoValid;
        oeA_d = {{8{!bus_a_high_byte_enable_n}}, {8{!bus_a_low_byte_enable_n}}}; // RL14
        oeB_d = {{8{!bus_b_high_byte_enable_n}}, {8{!bus_b_low_byte_enable_n}}}; // RL14
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dirA_q     <= 16'h0000;
            dirB_q     <= 16'h0000;
            bus_q      <= '0;
            oeA_q      <= 16'h0000;
            oeB_q      <= 16'h0000;
            strobeN_q  <= 1'b1;
            valid_q    <= 1'b0;
        end else begin
            dirA_q     <= dirA_d;
            dirB_q     <= dirB_d;
            bus_q      <= bus_d; // RL1
            oeA_q      <= oeA_d;
            oeB_q      <= oeB_d;
            strobeN_q  <= strobeN_d;
            valid_q    <= valid_d;
        end
    end

    assign outBus            = bus_q;
    assign output_bus_a_oe   = oeA_q;
    assign output_bus_b_oe   = oeB_q;
    assign new_data_strobe_n = strobeN_q;
    assign bufferValid       = valid_q;

    sequence s_strobePulse;
        !new_data_strobe_n ##1 new_data_strobe_n;
    endsequence

    property p_strobeOne;
        @(posedge clk) disable iff (!rst_b) sampleValid ##1 !sampleValid |-> s_strobePulse;
    endproperty
    a_strobeOne: assert property (p_strobeOne) else $error("Strobe not one cycle"); // RL12

    property p_strobeIdle;
        @(posedge clk) disable iff (!rst_b)
            !sampleValid |=> new_data_strobe_n;
    endproperty
    a_strobeIdle: assert property (p_strobeIdle) else $error("Strobe without new data"); // RL12

    property p_strobeData;
        @(posedge clk) disable iff (!rst_b)
            (sampleValid && aSourceSel == `DPOP_ASRC_I)
                |=> outBus.busA[15:8] == $past(sample.inPhase[15:8]);
    endproperty
    a_strobeData: assert property (p_strobeData) else $error("Bus A high not direct"); // RL2

    property p_directA;
        @(posedge clk) disable iff (!rst_b)
            (sampleValid && aSourceSel == `DPOP_ASRC_FREQ)
                |=> outBus.busA[15:8] == $past(sample.freq[15:8]);
    endproperty
    a_directA: assert property (p_directA) else $error("Bus A source wrong"); // RL4

    property p_magSign;
        @(posedge clk) disable iff (!rst_b)
            (sampleValid && bSourceSel == `DPOP_BSRC_MAG) |=> !outBus.busB[15];
    endproperty
    a_magSign: assert property (p_magSign) else $error("Magnitude MSB set"); // RL6

    property p_bLow;
        @(posedge clk) disable iff (!rst_b)
            (sampleValid && !bLowFromBuffer && bSourceSel == `DPOP_BSRC_Q)
                |=> outBus.busB[7:0] == $past(sample.quad[7:0]);
    endproperty
    a_bLow: assert property (p_bLow) else $error("Bus B low source wrong"); // RL10

    property p_unassigned;
        @(posedge clk) disable iff (!rst_b) (itemSel > 3'h4) |=> outBus.busA[7:0] == 8'h00;
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("Unassigned code not zero"); // RL16

    property p_enable;
        @(posedge clk) disable iff (!rst_b)
            bus_a_low_byte_enable_n |=> output_bus_a_oe[7:0] == 8'h00;
    endproperty
    a_enable: assert property (p_enable) else $error("Byte driven while disabled"); // RL14

    property p_bufWord;
        @(posedge clk) disable iff (!rst_b)
            (fifoValid && itemSel == `DPOP_SEL_I && bLowFromBuffer && !bufferPop && !setComplete)
                |=> {outBus.busA[7:0], outBus.busB[7:0]} == $past(headSet.inPhase);
    endproperty
    a_bufWord: assert property (p_bufWord) else $error("Buffered word wrong"); // RL9

    property p_bufFreq;
        @(posedge clk) disable iff (!rst_b)
            (fifoValid && itemSel == `DPOP_SEL_FREQ)
                |=> outBus.busA[7:0] == $past(headSet.freq[15:8]);
    endproperty
    a_bufFreq: assert property (p_bufFreq) else $error("Buffered item not selected"); // RL7

    property p_bufQuadLow;
        @(posedge clk) disable iff (!rst_b)
            (fifoValid && itemSel == `DPOP_SEL_Q && bLowFromBuffer)
                |=> outBus.busB[7:0] == $past(headSet.quad[7:0]);
    endproperty
    a_bufQuadLow: assert property (p_bufQuadLow) else $error("Bus B low not buffered"); // RL10

    property p_bufMagSign;
        @(posedge clk) disable iff (!rst_b)
            (fifoValid && itemSel == `DPOP_SEL_MAG) |=> !outBus.busA[7];
    endproperty
    a_bufMagSign: assert property (p_bufMagSign) else $error("Buffered magnitude MSB set"); // RL11

    property p_unassignedB;
        @(posedge clk) disable iff (!rst_b)
            (itemSel > 3'h4 && bLowFromBuffer) |=> outBus.busB[7:0] == 8'h00;
    endproperty
    a_unassignedB: assert property (p_unassignedB) else $error("Unassigned low not zero"); // RL16

    property p_emptyZero;
        @(posedge clk) disable iff (!rst_b)
            !fifoValid |=> outBus.busA[7:0] == 8'h00;
    endproperty
    a_emptyZero: assert property (p_emptyZero) else $error("Empty queue word not zero"); // RL9

    property p_directB;
        @(posedge clk) disable iff (!rst_b)
            (sampleValid && !bLowFromBuffer && bSourceSel == `DPOP_BSRC_PHASE)
                |=> outBus.busB == $past(sample.phase);
    endproperty
    a_directB: assert property (p_directB) else $error("Bus B source wrong"); // RL5

    property p_directMagA;
        @(posedge clk) disable iff (!rst_b)
            (sampleValid && aSourceSel == `DPOP_ASRC_MAG)
                |=> outBus.busA[15:8] == {1'b0, $past(sample.mag[14:8])};
    endproperty
    a_directMagA: assert property (p_directMagA) else $error("Bus A magnitude wrong"); // RL6

    property p_directHold;
        @(posedge clk) disable iff (!rst_b)
            !sampleValid
                |=> $stable(outBus.busA[15:8]) && $stable(outBus.busB[15:8]);
    endproperty
    a_directHold: assert property (p_directHold) else $error("Direct bytes moved"); // RL3

    property p_validTrack;
        @(posedge clk) disable iff (!rst_b)
            (setComplete && !fifoValid) |=> ##1 bufferValid;
    endproperty
    a_validTrack: assert property (p_validTrack) else $error("Buffer valid missing"); // RL7

    property p_irqOnPush;
        @(posedge clk) disable iff (!rst_b)
            (setComplete && !fifoValid) |=> !buffer_ready_irq_n;
    endproperty
    a_irqOnPush: assert property (p_irqOnPush) else $error("Interrupt missing"); // RL13

    property p_enableAH;
        @(posedge clk) disable iff (!rst_b)
            bus_a_high_byte_enable_n |=> output_bus_a_oe[15:8] == 8'h00;
    endproperty
    a_enableAH: assert property (p_enableAH) else $error("A high driven while disabled"); // RL14

    property p_enableBH;
        @(posedge clk) disable iff (!rst_b)
            bus_b_high_byte_enable_n |=> output_bus_b_oe[15:8] == 8'h00;
    endproperty
    a_enableBH: assert property (p_enableBH) else $error("B high driven while disabled"); // RL14

    property p_enableBL;
        @(posedge clk) disable iff (!rst_b)
            bus_b_low_byte_enable_n |=> output_bus_b_oe[7:0] == 8'h00;
    endproperty
    a_enableBL: assert property (p_enableBL) else $error("B low driven while disabled"); // RL14

    property p_driveAll;
        @(posedge clk) disable iff (!rst_b)
            (!bus_a_high_byte_enable_n && !bus_a_low_byte_enable_n && !bus_b_high_byte_enable_n &&
             !bus_b_low_byte_enable_n) |=> (output_bus_a_oe & output_bus_b_oe) == 16'hFFFF;
    endproperty
    a_driveAll: assert property (p_driveAll) else $error("Enabled byte not driven"); // RL14
endmodule : dpop_output_ports
`default_nettype wire

// *** dv/dpop_reader_model.sv ***
// Reader model standing on the far side of the output buses.
// Assumes the bench hands it commands on clock edges by non-blocking assignment.
`timescale 1ns/10ps
`default_nettype none
module dpop_reader_model (
    input  wire logic [2:0] selCmd,
    input  wire logic       popCmd,
    input  wire logic [3:0] enCmd,
    output logic [2:0]      itemSel,
    output logic            bufferPop,
    output logic            enAHighN,
    output logic            enALowN,
    output logic            enBHighN,
    output logic            enBLowN
);
    // Reader picks the buffered item, weight msb first
    assign itemSel   = selCmd;
    assign bufferPop = popCmd;
    // Each byte enable is the reader's own level; high lets the byte float
    assign enAHighN  = enCmd[3];
    assign enALowN   = enCmd[2];
    assign enBHighN  = enCmd[1];
    assign enBLowN   = enCmd[0];
endmodule : dpop_reader_model
`default_nettype wire

// *** dv/dual_parallel_output_ports_tb.sv ***
// Self-checking bench for the dual parallel output ports.
// Assumes the reader model for selector, pop and byte enables.
`timescale 1ns/10ps
`default_nettype none
module dual_parallel_output_ports_tb;
    import dpop_pkg::*;
    logic        clk, rst_b, sampleValid, bLowFromBuffer, setComplete, popCmd;
    logic [1:0]  aSourceSel, bSourceSel;
    logic [2:0]  selCmd, itemSel;
    logic [3:0]  enCmd;
    dpop_set_t   sample;
    dpop_bus_t   outBus;
    logic [15:0] oeA, oeB;
    logic        strobeN, irqN, bufferValid, bufferPop, enAH, enAL, enBH, enBL;
    int          n_mismatch, samples_checked;

    dpop_output_ports dut_u (.clk(clk), .rst_b(rst_b), .sampleValid(sampleValid),
        .sample(sample), .aSourceSel(aSourceSel), .bSourceSel(bSourceSel),
        .bLowFromBuffer(bLowFromBuffer), .setComplete(setComplete), .bufferPop(bufferPop),
        .itemSel(itemSel), .bus_a_high_byte_enable_n(enAH), .bus_a_low_byte_enable_n(enAL),
        .bus_b_high_byte_enable_n(enBH), .bus_b_low_byte_enable_n(enBL), .outBus(outBus),
        .output_bus_a_oe(oeA), .output_bus_b_oe(oeB), .new_data_strobe_n(strobeN),
        .buffer_ready_irq_n(irqN), .bufferValid(bufferValid));
    dpop_reader_model reader_u (.selCmd(selCmd), .popCmd(popCmd), .enCmd(enCmd),
        .itemSel(itemSel), .bufferPop(bufferPop), .enAHighN(enAH), .enALowN(enAL),
        .enBHighN(enBH), .enBLowN(enBL));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic finish_test;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // Push one set; pulse both strobes for one edge
    task automatic push(input dpop_set_t s);
        @(posedge clk);
        sample <= s;
        sampleValid <= 1'b1;
        setComplete <= 1'b1;
        @(posedge clk);
        sampleValid <= 1'b0;
        setComplete <= 1'b0;
    endtask : push

    task automatic run_direct;
        dpop_set_t s;
        logic [15:0] ea [3];
        logic [15:0] eb [3];
        s = {16'h1234, 16'h5678, 16'hF0AB, 16'h9ABC, 16'hDE01};
        ea = '{s.inPhase, s.mag & 16'h7FFF, s.freq};
        eb = '{s.quad, s.phase, s.mag & 16'h7FFF};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            aSourceSel <= k[1:0];
            bSourceSel <= k[1:0];
            sample <= s;
            sampleValid <= 1'b1;
            @(posedge clk);
            sampleValid <= 1'b0;
            #1;
            chk("directAHigh", {8'h00, ea[k][15:8]}, {8'h00, outBus.busA[15:8]});
            chk("directB", eb[k], outBus.busB);
            chk("strobeLow", 16'h0000, {15'h0, strobeN});
            @(posedge clk);
            #1;
            chk("strobeHigh", 16'h0001, {15'h0, strobeN});
        end
    endtask : run_direct

    task automatic run_buffered;
        dpop_set_t s;
        logic [15:0] e [8];
        int lows;
        s = {16'h8123, 16'h4567, 16'hC9AB, 16'h2DEF, 16'hE135};
        e = '{s.inPhase, s.quad, s.mag & 16'h7FFF, s.phase, s.freq, 16'h0, 16'h0, 16'h0};
        @(posedge clk);
        bLowFromBuffer <= 1'b1;
        push(s);
        lows = 0;
        for (int c = 0; c < 10; c++) begin
            #1;
            lows += (irqN === 1'b0);
            @(posedge clk);
        end
        chk("irqCycles", 16'h0008, lows[15:0]);
        chk("bufferValid", 16'h0001, {15'h0, bufferValid});
        for (int j = 0; j < 8; j++) begin
            @(posedge clk);
            selCmd <= j[2:0];
            @(posedge clk);
            #1;
            chk("bufferedItem", e[j], {outBus.busA[7:0], outBus.busB[7:0]});
        end
        @(posedge clk);
        selCmd <= 3'h0;
        popCmd <= 1'b1;
        @(posedge clk);
        popCmd <= 1'b0;
        @(posedge clk);
        #1;
        chk("emptyAfterPop", 16'h0000, {15'h0, bufferValid});
    endtask : run_buffered

    task automatic run_fill;
        for (int i = 0; i < 8; i++)
            push({16'hA000 + 16'(i), 64'h0});
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            #1;
            chk("queueHead", 16'hA000 + 16'(i), {outBus.busA[7:0], outBus.busB[7:0]});
            @(posedge clk);
            popCmd <= 1'b1;
            @(posedge clk);
            popCmd <= 1'b0;
        end
        @(posedge clk);
        #1;
        chk("eighthDropped", 16'h0000, {15'h0, bufferValid});
    endtask : run_fill

    task automatic run_enables;
        for (int b = 0; b < 5; b++) begin
            @(posedge clk);
            enCmd <= 4'(1 << b);
            @(posedge clk);
            @(posedge clk);
            #1;
            chk("oeA", {{8{~enCmd[3]}}, {8{~enCmd[2]}}}, oeA);
            chk("oeB", {{8{~enCmd[1]}}, {8{~enCmd[0]}}}, oeB);
        end
    endtask : run_enables

    initial begin
        rst_b = 1'b0;
        sampleValid = 1'b0;
        setComplete = 1'b0;
        bLowFromBuffer = 1'b0;
        popCmd = 1'b0;
        aSourceSel = 2'h0;
        bSourceSel = 2'h0;
        selCmd = 3'h0;
        enCmd = 4'hF;
        sample = '0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        enCmd <= 4'h0;
        #1;
        chk("rstBus", 16'h0000, outBus.busA | outBus.busB);
        chk("rstOe", 16'h0000, oeA | oeB);
        chk("rstFlags", 16'h0006, {13'h0, strobeN, irqN, bufferValid});
        run_direct();
        run_buffered();
        run_fill();
        run_enables();
        finish_test();
    end

    // Hang guard: a stuck run counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
endmodule : dual_parallel_output_ports_tb
`default_nettype wire
